// File: xcvr_housekeeping.sv
/*
 * Top of the transceiver housekeeping: AXI4-Lite registers, reset sequencing,
 * clock output, lock status and IF gain.
 * Assumes clk is the crystal reference domain and hw_reset_pin is asynchronous.
 */
`timescale 1ns/1ps
`include "xcvr_defines.svh"
module xcvr_housekeeping #(
    parameter int unsigned POR_CYCLES = (`POR_TIME_US * (`CLK_HZ / 1000000)),
    parameter int unsigned REC_CYCLES = (`MAN_RECOVER_TIME_US * (`CLK_HZ / 1000000)) + 1,
    parameter int unsigned DIV_W      = 8
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Reset pin, open drain
    input  wire logic        hw_reset_pin_in,
    output logic             hw_reset_pin_out,
    output logic             hw_reset_pin_oe,
    // Analog side
    input  wire logic        pll_lock,
    output logic             ref_clock_out,
    output logic             ref_clock_oe,
    output logic             lock_detect_pin,
    output logic             lock_detect_oe,
    output xcvr_pkg::if_gain_t if_gain,
    output xcvr_pkg::chip_mode_e chip_mode,
    // Interrupt
    output logic             irq
);
    import xcvr_pkg::*;

    initial begin
        if (DIV_W < 1 || DIV_W > 16) begin
            $error("xcvr_housekeeping: DIV_W out of range");
        end
    end

    xcvr_ctl_if ctl ();

    // Pin and lock come from outside the clock domain: two flops before any logic
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic lock_meta_reg;
    logic lock_sync_reg;
    logic lock_prev_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_reg  <= 1'b0;
            pin_sync_reg  <= 1'b0;
            lock_meta_reg <= 1'b0;
            lock_sync_reg <= 1'b0;
            lock_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg  <= hw_reset_pin_in;
            pin_sync_reg  <= pin_meta_reg;
            lock_meta_reg <= pll_lock;
            lock_sync_reg <= lock_meta_reg;
            lock_prev_reg <= lock_sync_reg;
        end
    end

    assign ctl.pin_sync = pin_sync_reg;

    reset_sequencer #(
        .POR_CYCLES (POR_CYCLES),
        .REC_CYCLES (REC_CYCLES)
    ) u_seq (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ctl     (ctl)
    );

    wire in_reset = ctl.in_reset;

    // Response codes of the bus
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Bus handshake: write address and data may come in either order
    logic        aw_held_reg;
    logic [11:0] aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        rvalid_reg;
    logic        bvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [1:0]  bresp_reg;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire wr_go   = aw_held_reg && w_held_reg;

    wire hit_ctrl  = (aw_addr_reg == `OFF_CTRL);
    wire hit_div   = (aw_addr_reg == `OFF_CLKDIV);
    wire hit_stat  = (aw_addr_reg == `OFF_STATUS);
    wire hit_istat = (aw_addr_reg == `OFF_IRQ_STATUS);
    wire hit_imask = (aw_addr_reg == `OFF_IRQ_MASK);
    wire wr_map    = hit_ctrl || hit_div || hit_stat || hit_istat || hit_imask;
    // Writes in reset still complete on the bus but change nothing
    wire wr_ok     = wr_go && !in_reset && w_strb_reg[0];

    // Control state
    chip_mode_e           mode_reg;
    logic                 lock_pin_enable_reg;
    if_gain_t             gain_reg;
    logic [DIV_W-1:0]     div_reg;
    logic                 lock_status_flag_reg;
    logic [`IRQ_BITS-1:0] irq_status_reg;
    logic [`IRQ_BITS-1:0] irq_mask_reg;

    wire [2:0] mode_wr = w_data_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    wire mode_legal    = (mode_wr <= MODE_TX);
    wire lock_rise     = lock_sync_reg && !lock_prev_reg;
    wire lock_fall     = !lock_sync_reg && lock_prev_reg;
    wire lock_clr      = wr_ok && hit_stat && w_data_reg[`STATUS_LOCK_FLAG];
    wire [`IRQ_BITS-1:0] irq_events = {ctl.ready_pulse, lock_fall, lock_rise};
    wire [`IRQ_BITS-1:0] irq_clr    = (wr_ok && hit_istat) ? w_data_reg[`IRQ_BITS-1:0] : '0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg            <= MODE_STANDBY;
            lock_pin_enable_reg <= 1'b0;
            gain_reg            <= `GAIN_RESET;
            div_reg             <= DIV_W'(`CLKDIV_RESET);
        end else if (in_reset) begin
            mode_reg            <= MODE_STANDBY;
            lock_pin_enable_reg <= 1'b0;
            gain_reg            <= `GAIN_RESET;
            div_reg             <= DIV_W'(`CLKDIV_RESET);
        end else if (wr_ok && hit_ctrl) begin
            if (mode_legal) begin
                mode_reg <= chip_mode_e'(mode_wr);
            end
            lock_pin_enable_reg <= w_data_reg[`CTRL_LOCK_PIN_EN];
            gain_reg            <= w_data_reg[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB];
        end else if (wr_ok && hit_div) begin
            div_reg <= w_data_reg[DIV_W-1:0];
        end
    end

    // Flag re-sets while lock stays high, so a clear only sticks once lock drops
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_status_flag_reg <= 1'b0;
            irq_status_reg       <= '0;
            irq_mask_reg         <= '0;
        end else begin
            if (in_reset) begin
                lock_status_flag_reg <= 1'b0;
            end else if (lock_sync_reg) begin
                lock_status_flag_reg <= 1'b1;
            end else if (lock_clr) begin
                lock_status_flag_reg <= 1'b0;
            end
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_events;
            if (wr_ok && hit_imask) begin
                irq_mask_reg <= w_data_reg[`IRQ_BITS-1:0];
            end
        end
    end

    // Read decode
    // Reads are served in reset as well; only writes are gated
    wire [31:0] ctrl_rd = {26'h0, gain_reg, lock_pin_enable_reg, mode_reg};
    wire [31:0] div_rd  = 32'(div_reg);
    wire [31:0] stat_rd = {29'h0, lock_sync_reg, in_reset, lock_status_flag_reg};
    wire [31:0] ist_rd  = 32'(irq_status_reg);
    wire [31:0] imk_rd  = 32'(irq_mask_reg);
    wire rd_ctrl = (s_axi_araddr == `OFF_CTRL);
    wire rd_div  = (s_axi_araddr == `OFF_CLKDIV);
    wire rd_stat = (s_axi_araddr == `OFF_STATUS);
    wire rd_ist  = (s_axi_araddr == `OFF_IRQ_STATUS);
    wire rd_imk  = (s_axi_araddr == `OFF_IRQ_MASK);
    wire rd_map  = rd_ctrl || rd_div || rd_stat || rd_ist || rd_imk;
    wire [31:0] rd_mux = rd_ctrl ? ctrl_rd :
                         rd_div  ? div_rd  :
                         rd_stat ? stat_rd :
                         rd_ist  ? ist_rd  :
                         rd_imk  ? imk_rd  : 32'h0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h0;
        end else if (aw_fire) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else if (w_fire) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_reg <= 1'b0;
        end
    end

    // Response waits for both halves, so address and data may arrive apart
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= 2'h0;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read data is captured at the address handshake and held until taken
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= 2'h0;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // Clock output runs from power-up and parks in sleep
    wire clk_en = (mode_reg != MODE_SLEEP);

    clock_divider #(
        .DIV_W (DIV_W)
    ) u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (clk_en),
        .divisor (div_reg),
        .clk_out (ref_clock_out)
    );

    assign ref_clock_oe     = clk_en;
    assign hw_reset_pin_out = 1'b0;
    assign hw_reset_pin_oe  = ctl.pin_oe;
    assign lock_detect_pin  = lock_pin_enable_reg & lock_sync_reg;
    assign lock_detect_oe   = lock_pin_enable_reg && (mode_reg != MODE_SLEEP);
    assign if_gain          = gain_reg;
    assign chip_mode        = mode_reg;
    // Level output: high until every pending unmasked bit is cleared or masked
    assign irq              = |(irq_status_reg & irq_mask_reg);
endmodule

// File: xcvr_defines.svh
/*
 * Constants of the transceiver housekeeping block: register offsets, field
 * positions, reset values and timing figures.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef XCVR_DEFINES_SVH
`define XCVR_DEFINES_SVH

`define CLK_HZ              20000000
`define POR_TIME_US         10000
`define MAN_RECOVER_TIME_US 5000
`define HW_RESET_TIME_US    100

`define OFF_CTRL            12'h000
`define OFF_CLKDIV          12'h004
`define OFF_STATUS          12'h008
`define OFF_IRQ_STATUS      12'h00c
`define OFF_IRQ_MASK        12'h010

`define CTRL_MODE_LSB       0
`define CTRL_MODE_MSB       2
`define CTRL_LOCK_PIN_EN    3
`define CTRL_GAIN_LSB       4
`define CTRL_GAIN_MSB       5

`define STATUS_LOCK_FLAG    0
`define STATUS_IN_RESET     1
`define STATUS_PLL_LOCK     2

`define IRQ_LOCK_SET        0
`define IRQ_LOCK_LOST       1
`define IRQ_READY           2
`define IRQ_BITS            3

`define CLKDIV_RESET        8'h01
`define GAIN_RESET          2'h3
`define MODE_RESET          3'h1

`endif

// File: xcvr_pkg.sv
/*
 * Types of the transceiver housekeeping block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package xcvr_pkg;
    typedef enum logic [1:0] {
        RST_POR     = 2'b00,
        RST_MANUAL  = 2'b01,
        RST_RECOVER = 2'b10,
        RST_READY   = 2'b11
    } rst_state_e;

    typedef enum logic [2:0] {
        MODE_SLEEP   = 3'b000,
        MODE_STANDBY = 3'b001,
        MODE_FS      = 3'b010,
        MODE_RX      = 3'b011,
        MODE_TX      = 3'b100
    } chip_mode_e;

    // Gain code 0 is the highest gain, 3 is 0 dB
    typedef logic [1:0] if_gain_t;
endpackage

// File: xcvr_ctl_if.sv
/*
 * Carrier between the top module and its reset sequencer.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface xcvr_ctl_if;
    logic pin_sync;
    logic in_reset;
    logic ready_pulse;
    logic pin_oe;

    modport seq (input pin_sync, output in_reset, output ready_pulse, output pin_oe);
    modport top (output pin_sync, input in_reset, input ready_pulse, input pin_oe);
endinterface

// File: reset_sequencer.sv
/*
 * Reset sequencer: power-on window, manual reset pin handling, recovery wait.
 * Assumes the reset pin is already synchronised to clk.
 */
`timescale 1ns/1ps
`include "xcvr_defines.svh"
module reset_sequencer #(
    parameter int unsigned POR_CYCLES = (`POR_TIME_US * (`CLK_HZ / 1000000)),
    parameter int unsigned REC_CYCLES = (`MAN_RECOVER_TIME_US * (`CLK_HZ / 1000000)) + 1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Towards top
    xcvr_ctl_if.seq   ctl
);
    import xcvr_pkg::*;

    initial begin
        if (POR_CYCLES < 1 || REC_CYCLES < 1 || POR_CYCLES > 32'h7fffffff) begin
            $error("reset_sequencer: bad cycle counts");
        end
    end

    rst_state_e  state_reg;
    rst_state_e  state_next;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;

    wire por_done = (cnt_reg >= POR_CYCLES - 1);
    wire rec_done = (cnt_reg >= REC_CYCLES - 1);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 32'h1;
        unique case (state_reg)
            RST_POR: begin
                if (por_done) begin
                    state_next = RST_READY;
                    cnt_next   = 32'h0;
                end
            end
            RST_MANUAL: begin
                cnt_next = 32'h0;
                if (!ctl.pin_sync) begin
                    state_next = RST_RECOVER;
                end
            end
            RST_RECOVER: begin
                if (ctl.pin_sync) begin
                    state_next = RST_MANUAL;
                    cnt_next   = 32'h0;
                end else if (rec_done) begin
                    state_next = RST_READY;
                    cnt_next   = 32'h0;
                end
            end
            RST_READY: begin
                cnt_next = 32'h0;
                if (ctl.pin_sync) begin
                    state_next = RST_MANUAL;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= RST_POR;
            cnt_reg   <= 32'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign ctl.in_reset    = (state_reg != RST_READY);
    assign ctl.ready_pulse = (state_reg != RST_READY) && (state_next == RST_READY);
    // The pin is left released while power-on runs and reads low; we only release it
    assign ctl.pin_oe      = 1'b0;
endmodule

// File: clock_divider.sv
/*
 * Reference clock output divider.
 * Assumes clk stands in for the crystal reference.
 */
`timescale 1ns/1ps
module clock_divider #(
    parameter int unsigned DIV_W = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Control
    input  wire logic             enable,
    input  wire logic [DIV_W-1:0] divisor,
    // Output
    output logic                  clk_out
);
    initial begin
        if (DIV_W < 1 || DIV_W > 16) begin
            $error("clock_divider: DIV_W out of range");
        end
    end

    logic [DIV_W-1:0] cnt_reg;
    wire              wrap = (cnt_reg >= divisor - DIV_W'(1)) || (divisor == '0);

    // Output toggles each divisor cycles: period is twice the divisor
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            clk_out <= 1'b0;
        end else if (!enable) begin
            cnt_reg <= '0;
            clk_out <= 1'b0;
        end else if (wrap) begin
            cnt_reg <= '0;
            clk_out <= ~clk_out;
        end else begin
            cnt_reg <= cnt_reg + DIV_W'(1);
        end
    end
endmodule

// File: host_pin_model.sv
/*
 * Host side of the reset pin: drives a manual reset pulse on request.
 * Assumes the bench raises start for one cycle, after a rising edge.
 */
`timescale 1ns/1ps
module host_pin_model #(
    parameter int unsigned PULSE_CYCLES = 2000
) (
    // Clock
    input  wire logic clk,
    // Request from bench
    input  wire logic start,
    // Device pin drive
    input  wire logic dev_out,
    input  wire logic dev_oe,
    // Wire and host state
    output logic      pin_level,
    output logic      busy
);
    int unsigned cnt = 0;

    always @(posedge clk) begin
        if (start && cnt == 0) begin
            cnt <= PULSE_CYCLES;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end

    assign busy = (cnt != 0);
    // Released pin settles low; a stale high would look like a reset
    assign pin_level = dev_oe ? dev_out : busy;
endmodule

// File: hk_checker.sv
/*
 * Port-level assertions of the housekeeping block.
 * Assumes one clock domain with an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`include "xcvr_defines.svh"
module hk_checker
    import xcvr_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    // Register bus
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    // Pins
    input wire logic                 hw_reset_pin_in,
    input wire logic                 hw_reset_pin_oe,
    input wire logic                 pll_lock,
    input wire logic                 ref_clock_oe,
    input wire logic                 lock_detect_pin,
    input wire logic                 lock_detect_oe,
    input wire xcvr_pkg::if_gain_t   if_gain,
    input wire xcvr_pkg::chip_mode_e chip_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ref_oe_mode_a: assert property (ref_clock_oe == (chip_mode != MODE_SLEEP))
        else $error("clock output enable does not follow mode");
    lock_float_a: assert property (!lock_detect_oe && chip_mode != MODE_SLEEP |-> !lock_detect_pin)
        else $error("lock pin active while disabled");
    lock_follow_a: assert property (pll_lock [*4] ##0 lock_detect_oe |-> lock_detect_pin)
        else $error("lock pin does not show lock");
    pin_released_a: assert property (!hw_reset_pin_oe)
        else $error("reset pin actively driven");
    manual_default_a: assert property (hw_reset_pin_in [*5] |-> if_gain == `GAIN_RESET && chip_mode == MODE_STANDBY)
        else $error("settings not at defaults in manual reset");
    por_default_a: assert property ($fell(sys_rst) |-> if_gain == `GAIN_RESET && chip_mode == MODE_STANDBY)
        else $error("settings not at defaults after reset");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##[0:2] s_axi_bvalid)
        else $error("write response missing");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> ##[0:1] s_axi_rvalid)
        else $error("read response missing");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule

bind xcvr_housekeeping hk_checker hk_checker_inst (.*);

// File: testbench.sv
/*
 * Self-checking bench of the housekeeping block: power-on, register table,
 * lock flag and interrupt, divider and sleep, manual reset.
 * Assumes shortened reset windows set through the top parameters.
 */
`timescale 1ns/1ps
`include "xcvr_defines.svh"
module testbench;
    import xcvr_pkg::*;
    localparam int POR = 50;
    localparam int REC = 20;
    typedef struct {
        logic        wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0]  r;
        if_gain_t    g;
    } row_s;
    logic        clk = 1'b0, sys_rst = 1'b1, pll_lock = 1'b0, start = 1'b0, v;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        hw_reset_pin_in, hw_reset_pin_out, hw_reset_pin_oe, busy;
    logic        ref_clock_out, ref_clock_oe, lock_detect_pin, lock_detect_oe, irq;
    if_gain_t    if_gain;
    chip_mode_e  chip_mode;
    int          err_total = 0, n_compared = 0, cyc = 0, t0, n;
    row_s        rows [11];

    xcvr_housekeeping #(.POR_CYCLES(POR), .REC_CYCLES(REC)) xcvr_housekeeping_inst (.*);
    host_pin_model host_pin_model_inst (.clk(clk), .start(start), .dev_out(hw_reset_pin_out),
        .dev_oe(hw_reset_pin_oe), .pin_level(hw_reset_pin_in), .busy(busy));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ad, wd, ha, hw;
        ad = 0;
        wd = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge clk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            ad |= ha;
            wd |= hw;
        end
        do begin
            @(negedge clk);
            ha = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
        end while (!ha);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        bit h;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            h = s_axi_arready;
            @(posedge clk);
        end while (!h);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge clk);
            h = s_axi_rvalid;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
        end while (!h);
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_ready();
        do rd(`OFF_STATUS, rv); while (rv[1] !== 1'b0);
    endtask

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        forever #25 clk = ~clk;
    end

    // Whole run is a few thousand cycles; the limit leaves wide margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        rows = '{'{1'b0, `OFF_CTRL, 32'h0, 32'h31, 2'h0, 2'h3},
                 '{1'b0, `OFF_CLKDIV, 32'h0, 32'h1, 2'h0, 2'h3},
                 '{1'b0, `OFF_IRQ_MASK, 32'h0, 32'h0, 2'h0, 2'h3},
                 '{1'b0, 12'h100, 32'h0, 32'h0, 2'h2, 2'h3},
                 '{1'b1, `OFF_CTRL, 32'h01, 32'h01, 2'h0, 2'h0},
                 '{1'b1, `OFF_CTRL, 32'h11, 32'h11, 2'h0, 2'h1},
                 '{1'b1, `OFF_CTRL, 32'h21, 32'h21, 2'h0, 2'h2},
                 '{1'b1, `OFF_CTRL, 32'h32, 32'h32, 2'h0, 2'h3},
                 '{1'b1, `OFF_CTRL, 32'h34, 32'h34, 2'h0, 2'h3},
                 '{1'b1, `OFF_CTRL, 32'h31, 32'h31, 2'h0, 2'h3},
                 '{1'b1, `OFF_CTRL, 32'h35, 32'h31, 2'h0, 2'h3}};
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t0 = cyc;
        rd(`OFF_STATUS, rv);
        chk(rv[1], 1'b1);
        wr(`OFF_IRQ_MASK, 32'h7);
        chk(rsp, 2'h0);
        wr(`OFF_CTRL, 32'h0b);
        wait_ready();
        chk(cyc - t0 >= POR, 1'b1);
        rd(`OFF_CTRL, rv);
        chk(rv, 32'h31);
        rd(`OFF_IRQ_MASK, rv);
        chk(rv, 32'h0);
        rd(`OFF_IRQ_STATUS, rv);
        chk(rv, 32'h4);
        $display("done: power-on");
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rv);
            chk(rsp, rows[i].r);
            if (rsp === 2'h0) chk(rv, rows[i].e);
            chk(if_gain, rows[i].g);
            if (rows[i].a == `OFF_CTRL) chk(chip_mode, rows[i].e[2:0]);
        end
        wr(12'h100, 32'h0);
        chk(rsp, 2'h2);
        $display("done: register table");
        wr(`OFF_IRQ_STATUS, 32'h7);
        pll_lock <= 1'b1;
        wr(`OFF_CTRL, 32'h39);
        @(negedge clk);
        chk(lock_detect_oe, 1'b1);
        chk(lock_detect_pin, 1'b1);
        @(posedge clk);
        pll_lock <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`OFF_STATUS, rv);
        chk(rv, 32'h1);
        rd(`OFF_IRQ_STATUS, rv);
        chk(rv, 32'h3);
        @(negedge clk);
        chk(irq, 1'b0);
        wr(`OFF_IRQ_MASK, 32'h1);
        @(negedge clk);
        chk(irq, 1'b1);
        wr(`OFF_IRQ_STATUS, 32'h3);
        @(negedge clk);
        chk(irq, 1'b0);
        wr(`OFF_STATUS, 32'h1);
        rd(`OFF_STATUS, rv);
        chk(rv, 32'h0);
        wr(`OFF_CTRL, 32'h31);
        @(negedge clk);
        chk(lock_detect_oe, 1'b0);
        $display("done: lock and interrupt");
        wr(`OFF_CLKDIV, 32'h3);
        @(negedge clk);
        v = ref_clock_out;
        while (ref_clock_out === v) @(negedge clk);
        n = 0;
        v = ref_clock_out;
        do begin
            @(negedge clk);
            n++;
        end while (ref_clock_out === v);
        chk(n, 3);
        wr(`OFF_CTRL, 32'h30);
        @(negedge clk);
        chk(ref_clock_oe, 1'b0);
        wr(`OFF_CTRL, 32'h31);
        @(negedge clk);
        chk(ref_clock_oe, 1'b1);
        $display("done: divider and sleep");
        wr(`OFF_CTRL, 32'h0b);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        while (busy) @(negedge clk);
        t0 = cyc;
        rd(`OFF_STATUS, rv);
        chk(rv[1], 1'b1);
        wr(`OFF_IRQ_MASK, 32'h6);
        rd(`OFF_CTRL, rv);
        chk(rv, 32'h31);
        wr(`OFF_CTRL, 32'h0b);
        wait_ready();
        chk(cyc - t0 >= REC, 1'b1);
        rd(`OFF_CTRL, rv);
        chk(rv, 32'h31);
        rd(`OFF_IRQ_MASK, rv);
        chk(rv, 32'h1);
        rd(`OFF_IRQ_STATUS, rv);
        chk(rv, 32'h4);
        $display("done: manual reset");
        report_and_stop();
    end
endmodule
